// ### hw/echi_map.svh
// offsets, field positions, codes, reset values and timing figures
`ifndef ECHI_MAP_SVH
`define ECHI_MAP_SVH

// register offsets (byte addresses on the AXI4-Lite slave)
`define ECHI_OFF_STATUS   8'h00
`define ECHI_OFF_OS_EVT   8'h04
`define ECHI_OFF_MGMT_EVT 8'h08
`define ECHI_OFF_CTRL     8'h0C
`define ECHI_OFF_MEM      8'h10

// host status byte field positions
`define ECHI_ST_OBF       0
`define ECHI_ST_IBF       1
`define ECHI_ST_CMD       3
`define ECHI_ST_BURST     4
`define ECHI_ST_OS_EVT    5
`define ECHI_ST_MGMT_EVT  6

// control register field positions
`define ECHI_CTRL_CRIT    0
`define ECHI_CTRL_SMB_EN  1
`define ECHI_CTRL_HDR_LO  8

// command codes of the os set; the mgmt set has bit 6 set as well
`define ECHI_CMD_RD       8'h80
`define ECHI_CMD_WR       8'h81
`define ECHI_CMD_BURST_ON 8'h82
`define ECHI_CMD_BURST_OF 8'h83
`define ECHI_CMD_QUERY    8'h84
`define ECHI_MGMT_BIT     6
`define ECHI_BURST_ACK    8'h90
`define ECHI_QUERY_NONE   8'h00

// reset values
`define ECHI_BYTE_RST     8'h00
`define ECHI_HDR_RST      8'h00

// timing, figures in microseconds and the clock in MHz
`define ECHI_CLK_MHZ      10
`define ECHI_FIRST_US     400
`define ECHI_NEXT_US      50
`define ECHI_TOTAL_US     1000
`define ECHI_IBF_US       1

`endif

// ### hw/echi_pkg.sv
// types shared by the host command interface
package echi_pkg;

  // byte interpreter states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_RD_ADDR = 4'h2,
    ST_WR_ADDR = 4'h4,
    ST_WR_DATA = 4'h8
  } echi_state_t;

  // host environment that issued the running command
  typedef enum logic {
    ENV_OS   = 1'b0,
    ENV_MGMT = 1'b1
  } echi_env_t;

  typedef logic [7:0] echi_byte_t;

endpackage

// ### hw/echi_timeout.sv
// cycle timeout counter used for the burst mode time limits
module echi_timeout #(
  parameter int unsigned CYC = 500
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // control
  input  wire logic clear,
  input  wire logic run,
  // one-cycle pulse after CYC cycles of run without clear
  output logic      expired
);

  localparam int W = $clog2(CYC + 1);
  localparam logic [W-1:0] LAST = W'(CYC - 1);

  logic [W-1:0] cnt_q;

  // count run cycles; clear has priority so a fresh access restarts it
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt_q <= '0;
    end else if (run) begin
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end

  assign expired = run && !clear && (cnt_q == LAST);

endmodule

// ### hw/echi_top.sv
// host command and data interface with command interpreter and burst timer
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`include "echi_map.svh"

// Functional notes
// - command port write latches byte in input register and sets input full
// - command port write also sets the command byte flag
// - data port write latches byte in input register and sets input full
// - host data read returns output register and clears output full
// - commands: read 80, write 81, burst on 82, burst off 83, query 84
// - read: command, address byte, then addressed byte lands with output full
// - os read and write commands signal on os interrupt, not mgmt
// - write: command, address byte, data byte; data stored at address
// - burst ends on first 400us, next 50us or total 1ms timeout
// - burst leaves early on critical event and raises os interrupt then
// - burst keeps normal interrupts and answers each access within 50us
// - burst on sets burst bit, outputs 90, sets output full, interrupts
// - burst off clears burst bit and interrupts on input empty
// - during burst, firmware memory writes leave the bytes alone but still move the pointer; event posts and control writes still act
// - event: pending flag set first, interrupt after, then await query
// - query places the 8-bit notification value into the output buffer
// - query value zero means no outstanding event, never a real cause
// - parallel command set per environment; answers go to issuer
// - pending notifications survive all commands except a query from their own environment
// - event pending flag set only for a real event of that environment
// - notifications enter the output buffer only on a query command
// - optional header value reports integrated smbus host events
// - status: obf, ibf, cmd, burst, os and mgmt event; bits 2, 7 zero
// - input full clears when the controller consumes the captured byte
// - input full visible within 1us of a host write to either port
// - a data port write leaves the command byte flag cleared
module echi_top
  import echi_pkg::*;
#(
  parameter int unsigned TOTAL_CYC = `ECHI_TOTAL_US * `ECHI_CLK_MHZ
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // host port strobes, same clock as the block
  input  wire logic        host_wr_cmd,
  input  wire logic        host_wr_data,
  input  wire logic        host_rd_data,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  output logic      [7:0]  host_status,
  // interrupts and smbus event source
  output logic             os_interrupt,
  output logic             mgmt_interrupt,
  input  wire logic        smb_event,
  // axi4-lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp
);

  localparam int unsigned FIRST_CYC = `ECHI_FIRST_US * `ECHI_CLK_MHZ;
  localparam int unsigned NEXT_CYC  = `ECHI_NEXT_US * `ECHI_CLK_MHZ;
  localparam int IBF_MAX = `ECHI_IBF_US * `ECHI_CLK_MHZ;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  //////////////////////////////////////////////////////////////////////////
  // declarations
  echi_byte_t  ibuf_q, obuf_q, os_code_q, mgmt_code_q, hdr_q, mem_addr_q;
  logic        ibf_q, obf_q, cmd_q, burst_q, seen_q;
  logic        os_pend_q, mgmt_pend_q, smb_en_q, smb_wait_q;
  logic        os_evt_irq_q, mgmt_evt_irq_q;
  echi_state_t state_q;
  echi_env_t   env_q, byte_env;
  echi_byte_t  ram_q [256];
  echi_byte_t  addr_q;
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        consume, is_cmd_byte, host_access, obf_set, ram_host_we;
  logic        take_os, take_mgmt, wr_go, wr_err, crit;
  logic        post_os, post_mgmt, smb_post, burst_on, burst_off;
  logic        exp_first, exp_next, exp_total, burst_abort;
  echi_byte_t  cmd_code, obf_val;
  logic [31:0] rd_val;
  logic        rd_hit;

  //////////////////////////////////////////////////////////////////////////
  // host port: input buffer capture, set wins over consumption
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ibuf_q <= `ECHI_BYTE_RST;
      ibf_q  <= 1'b0;
      cmd_q  <= 1'b0;
    end else if (host_wr_cmd) begin
      ibuf_q <= host_wdata;
      ibf_q  <= 1'b1;
      cmd_q  <= 1'b1;
    end else if (host_wr_data) begin
      ibuf_q <= host_wdata;
      ibf_q  <= 1'b1;
      cmd_q  <= 1'b0;
    end else if (consume) begin
      ibf_q  <= 1'b0;
    end
  end

  // the interpreter takes each byte the cycle after it lands
  assign consume     = ibf_q;
  assign is_cmd_byte = cmd_q;
  assign cmd_code    = {ibuf_q[7], 1'b0, ibuf_q[5:0]};
  assign byte_env    = (is_cmd_byte && ibuf_q[`ECHI_MGMT_BIT]) ? ENV_MGMT :
                       (is_cmd_byte ? ENV_OS : env_q);
  assign host_access = host_wr_cmd || host_wr_data || host_rd_data;

  // command decode; the mgmt set mirrors the os set with bit 6 raised
  assign burst_on  = consume && is_cmd_byte &&
                     cmd_code == `ECHI_CMD_BURST_ON;
  assign burst_off = consume && is_cmd_byte &&
                     cmd_code == `ECHI_CMD_BURST_OF;
  assign take_os   = consume && is_cmd_byte && byte_env == ENV_OS &&
                     cmd_code == `ECHI_CMD_QUERY;
  assign take_mgmt = consume && is_cmd_byte && byte_env == ENV_MGMT &&
                     cmd_code == `ECHI_CMD_QUERY;
  assign ram_host_we = consume && !is_cmd_byte && state_q == ST_WR_DATA;

  //////////////////////////////////////////////////////////////////////////
  // byte sequencer: a command byte always restarts the sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      env_q   <= ENV_OS;
      addr_q  <= `ECHI_BYTE_RST;
    end else if (consume && is_cmd_byte) begin
      env_q <= byte_env;
      case (cmd_code)
        `ECHI_CMD_RD: state_q <= ST_RD_ADDR;
        `ECHI_CMD_WR: state_q <= ST_WR_ADDR;
        default:      state_q <= ST_IDLE;
      endcase
    end else if (consume) begin
      case (state_q)
        ST_WR_ADDR: begin
          addr_q  <= ibuf_q;
          state_q <= ST_WR_DATA;
        end
        default:    state_q <= ST_IDLE;          // stray data is dropped
      endcase
    end
  end

  // address space; the host write has priority, firmware waits a cycle
  always_ff @(posedge aclk) begin
    if (ram_host_we) begin
      ram_q[addr_q] <= ibuf_q;
    end else if (wr_go && aw_addr_q == `ECHI_OFF_MEM && !burst_q &&
                 w_strb_q[1:0] == 2'b11) begin
      ram_q[w_data_q[15:8]] <= w_data_q[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output buffer: written only as the answer to a host command
  always_comb begin
    obf_set = 1'b0;
    obf_val = `ECHI_QUERY_NONE;
    if (consume && !is_cmd_byte && state_q == ST_RD_ADDR) begin
      obf_set = 1'b1;
      obf_val = ram_q[ibuf_q];
    end else if (burst_on) begin
      obf_set = 1'b1;
      obf_val = `ECHI_BURST_ACK;
    end else if (take_os) begin
      obf_set = 1'b1;
      obf_val = os_pend_q ? os_code_q : `ECHI_QUERY_NONE;
    end else if (take_mgmt) begin
      obf_set = 1'b1;
      obf_val = mgmt_pend_q ? mgmt_code_q : `ECHI_QUERY_NONE;
    end
  end

  // a new answer wins over a host read in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      obuf_q <= `ECHI_BYTE_RST;
      obf_q  <= 1'b0;
    end else if (obf_set) begin
      obuf_q <= obf_val;
      obf_q  <= 1'b1;
    end else if (host_rd_data) begin
      obf_q  <= 1'b0;
    end
  end

  assign host_rdata = obuf_q;

  //////////////////////////////////////////////////////////////////////////
  // event queues, one slot per environment; a post never lands on a
  // pending slot, so a queued cause stays until a query from its own environment
  assign smb_post  = smb_wait_q && !os_pend_q && !post_os &&
                     hdr_q != `ECHI_QUERY_NONE;
  assign post_os   = wr_go && aw_addr_q == `ECHI_OFF_OS_EVT && w_strb_q[0] &&
                     w_data_q[7:0] != `ECHI_QUERY_NONE && !os_pend_q;
  assign post_mgmt = wr_go && aw_addr_q == `ECHI_OFF_MGMT_EVT &&
                     w_strb_q[0] && w_data_q[7:0] != `ECHI_QUERY_NONE &&
                     !mgmt_pend_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      os_pend_q <= 1'b0;
      os_code_q <= `ECHI_BYTE_RST;
    end else if (post_os || smb_post) begin
      os_pend_q <= 1'b1;
      os_code_q <= post_os ? w_data_q[7:0] : hdr_q;
    end else if (take_os) begin
      os_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mgmt_pend_q <= 1'b0;
      mgmt_code_q <= `ECHI_BYTE_RST;
    end else if (post_mgmt) begin
      mgmt_pend_q <= 1'b1;
      mgmt_code_q <= w_data_q[7:0];
    end else if (take_mgmt) begin
      mgmt_pend_q <= 1'b0;
    end
  end

  // smbus events wait for a free os slot; a new event wins over the post
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smb_wait_q <= 1'b0;
    end else if (smb_event && smb_en_q && hdr_q != `ECHI_QUERY_NONE) begin
      smb_wait_q <= 1'b1;
    end else if (smb_post) begin
      smb_wait_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // burst mode and its three time limits
  echi_timeout #(.CYC(FIRST_CYC)) u_first (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (!burst_q || host_access),
    .run     (burst_q && !seen_q),
    .expired (exp_first)
  );
  echi_timeout #(.CYC(NEXT_CYC)) u_next (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (!burst_q || host_access),
    .run     (burst_q && seen_q),
    .expired (exp_next)
  );
  echi_timeout #(.CYC(TOTAL_CYC)) u_total (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (!burst_q),
    .run     (burst_q),
    .expired (exp_total)
  );

  assign crit        = wr_go && aw_addr_q == `ECHI_OFF_CTRL && w_strb_q[0] &&
                       w_data_q[`ECHI_CTRL_CRIT];
  assign burst_abort = burst_q && !burst_off &&
                       (exp_first || exp_next || exp_total || crit);

  // entry wins over a timeout in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burst_q <= 1'b0;
      seen_q  <= 1'b0;
    end else if (burst_on) begin
      burst_q <= 1'b1;
      seen_q  <= 1'b0;
    end else if (burst_off || burst_abort) begin
      burst_q <= 1'b0;
    end else if (burst_q && host_access) begin
      seen_q  <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupts: one pulse per consumed byte to its issuer; event pulses
  // trail the pending flag by one cycle so the flag is already visible
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      os_evt_irq_q   <= 1'b0;
      mgmt_evt_irq_q <= 1'b0;
      os_interrupt   <= 1'b0;
      mgmt_interrupt <= 1'b0;
    end else begin
      os_evt_irq_q   <= post_os || smb_post;
      mgmt_evt_irq_q <= post_mgmt;
      os_interrupt   <= (consume && byte_env == ENV_OS) ||
                        burst_abort || os_evt_irq_q;
      mgmt_interrupt <= (consume && byte_env == ENV_MGMT) ||
                        mgmt_evt_irq_q;
    end
  end

  // status byte, ignored positions read zero
  always_comb begin
    host_status                    = 8'h00;
    host_status[`ECHI_ST_OBF]      = obf_q;
    host_status[`ECHI_ST_IBF]      = ibf_q;
    host_status[`ECHI_ST_CMD]      = cmd_q;
    host_status[`ECHI_ST_BURST]    = burst_q;
    host_status[`ECHI_ST_OS_EVT]   = os_pend_q;
    host_status[`ECHI_ST_MGMT_EVT] = mgmt_pend_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite write side: address and data held independently
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready  = !w_hold_q;
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid && !ram_host_we;
  assign wr_err = !(aw_addr_q == `ECHI_OFF_OS_EVT ||
                    aw_addr_q == `ECHI_OFF_MGMT_EVT ||
                    aw_addr_q == `ECHI_OFF_CTRL || aw_addr_q == `ECHI_OFF_MEM)
                  || (aw_addr_q == `ECHI_OFF_OS_EVT && os_pend_q)
                  || (aw_addr_q == `ECHI_OFF_MGMT_EVT && mgmt_pend_q)
                  || (aw_addr_q == `ECHI_OFF_MEM && burst_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else begin
      if (s_axi_awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? RESP_ERR : RESP_OK;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // firmware settings: smbus header value, its enable and memory pointer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hdr_q      <= `ECHI_HDR_RST;
      smb_en_q   <= 1'b0;
      mem_addr_q <= `ECHI_BYTE_RST;
    end else if (wr_go && aw_addr_q == `ECHI_OFF_CTRL) begin
      if (w_strb_q[0]) smb_en_q <= w_data_q[`ECHI_CTRL_SMB_EN];
      if (w_strb_q[1]) hdr_q <= w_data_q[`ECHI_CTRL_HDR_LO +: 8];
    end else if (wr_go && aw_addr_q == `ECHI_OFF_MEM && w_strb_q[1]) begin
      mem_addr_q <= w_data_q[15:8];
    end
  end

  // axi4-lite read side
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `ECHI_OFF_STATUS:   rd_val[7:0] = host_status;
      `ECHI_OFF_OS_EVT:   rd_val = {23'h0, os_pend_q, os_code_q};
      `ECHI_OFF_MGMT_EVT: rd_val = {23'h0, mgmt_pend_q, mgmt_code_q};
      `ECHI_OFF_CTRL:     rd_val = {16'h0, hdr_q, 6'h0, smb_en_q, burst_q};
      `ECHI_OFF_MEM:      rd_val = {16'h0, mem_addr_q, ram_q[mem_addr_q]};
      default:            rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OK;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? RESP_OK : RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [15:0] burst_len_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !burst_q) burst_len_q <= 16'h0000;
    else burst_len_q <= burst_len_q + 16'h0001;
  end

  cmd_capture_a: assert property (host_wr_cmd |=> ibf_q && cmd_q &&
    ibuf_q == $past(host_wdata)) else $error("command byte not captured");
  data_capture_a: assert property (host_wr_data && !host_wr_cmd |=>
    ibf_q && !cmd_q && ibuf_q == $past(host_wdata))
    else $error("data byte not captured");
  ibf_visible_a: assert property (host_wr_cmd || host_wr_data |->
    ##[1:IBF_MAX] host_status[`ECHI_ST_IBF]) else $error("ibf late");
  obf_clear_a: assert property (host_rd_data && !obf_set |=>
    !obf_q) else $error("obf not cleared by read");
  burst_ack_a: assert property (burst_on |=> burst_q && obf_q &&
    obuf_q == `ECHI_BURST_ACK) else $error("burst entry wrong");
  burst_off_a: assert property (burst_off && !burst_on |=> !burst_q &&
    (os_interrupt || mgmt_interrupt)) else $error("burst exit wrong");
  burst_total_a: assert property (burst_len_q <= TOTAL_CYC[15:0])
    else $error("burst outlived its total time");
  abort_irq_a: assert property (burst_abort && !burst_on |=> !burst_q &&
    os_interrupt) else $error("burst abort not reported");
  read_irq_a: assert property (consume && is_cmd_byte &&
    ibuf_q == `ECHI_CMD_RD |=> os_interrupt && !mgmt_interrupt)
    else $error("read command irq on wrong line");
  evt_order_a: assert property ($rose(os_pend_q) |=>
    os_interrupt) else $error("event irq not after flag");
  spurious_a: assert property (take_os && !os_pend_q |=>
    obuf_q == `ECHI_QUERY_NONE) else $error("spurious query nonzero");
  code_real_a: assert property (os_pend_q |->
    os_code_q != `ECHI_QUERY_NONE) else $error("zero code pending");
  obuf_source_a: assert property ($changed(obuf_q) |->
    $past(consume)) else $error("output loaded without command");

  burst_entry_c: cover property (burst_on ##1 burst_q);
  burst_timeout_c: cover property (burst_q && (exp_total || exp_next));
  query_event_c: cover property (take_os && os_pend_q);
  write_done_c: cover property (ram_host_we);

endmodule

// ### test/echi_host_model.sv
// host processor model that drives the command and data ports
module echi_host_model (
  // clock
  input  wire logic       aclk,
  // status and reply from the block
  input  wire logic [7:0] host_status,
  input  wire logic [7:0] host_rdata,
  // port strobes and written byte
  output logic            host_wr_cmd,
  output logic            host_wr_data,
  output logic            host_rd_data,
  output logic      [7:0] host_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    host_wr_cmd = 1'b0;
    host_wr_data = 1'b0;
    host_rd_data = 1'b0;
    host_wdata = 8'h00;
  end
  // one byte in, only once the input buffer is empty
  task put(input logic c, input logic [7:0] d);
    do @(posedge aclk); while (host_status[1] !== 1'b0);
    host_wr_cmd <= c;
    host_wr_data <= !c;
    host_wdata <= d;
    @(posedge aclk);
    host_wr_cmd <= 1'b0;
    host_wr_data <= 1'b0;
    host_wdata <= ~d; // released bus must not keep showing the byte
  endtask
  // one byte out, only once the output buffer is full
  task get(output logic [7:0] d);
    do @(posedge aclk); while (host_status[0] !== 1'b1);
    host_rd_data <= 1'b1;
    @(posedge aclk);
    d = host_rdata;
    host_rd_data <= 1'b0;
  endtask
endmodule

// ### test/ec_host_command_interface_bench.sv
// self-checking bench for the host command interface
`include "echi_map.svh"
module ec_host_command_interface_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, smb_event = 1'b0;
  logic host_wr_cmd, host_wr_data, host_rd_data, os_interrupt, mgmt_interrupt;
  logic [7:0] host_wdata, host_rdata, host_status, b;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int fail_count = 0, checked = 0, os_n = 0, mg_n = 0, n0;
  echi_top #(.TOTAL_CYC(200)) echi_top_i (.aclk, .aresetn, .host_wr_cmd,
    .host_wr_data, .host_rd_data, .host_wdata, .host_rdata, .host_status,
    .os_interrupt, .mgmt_interrupt, .smb_event, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  echi_host_model echi_host_model_i (.aclk, .host_status, .host_rdata,
    .host_wr_cmd, .host_wr_data, .host_rd_data, .host_wdata);
  always #50 aclk = ~aclk;
  // interrupt pulses last one cycle, so count them as they pass
  always @(posedge aclk) begin
    os_n += (os_interrupt === 1'b1);
    mg_n += (mgmt_interrupt === 1'b1);
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // byte in, then input full and the command flag must show at once
  task bin(input logic c, input logic [7:0] d);
    echi_host_model_i.put(c, d);
    #1;
    chk(host_status[1], 1'b1);
    chk(host_status[3], c);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_write;
    n0 = os_n;
    bin(1'b1, `ECHI_CMD_WR);
    bin(1'b0, 8'h3C);
    bin(1'b0, 8'hA5);
    repeat (3) @(posedge aclk);
    chk(os_n - n0, 3);
    chk(mg_n, 0);
  endtask
  task t_read;
    n0 = os_n;
    bin(1'b1, `ECHI_CMD_RD);
    bin(1'b0, 8'h3C);
    echi_host_model_i.get(b);
    chk(b, 8'hA5);
    chk(os_n - n0, 2);
    @(posedge aclk);
    #1;
    chk(host_status[0], 1'b0);
  endtask
  task t_burst;
    bin(1'b1, `ECHI_CMD_BURST_ON);
    echi_host_model_i.get(b);
    chk(b, `ECHI_BURST_ACK);
    chk(host_status[4], 1'b1);
    bin(1'b1, `ECHI_CMD_BURST_OF);
    repeat (3) @(posedge aclk);
    chk(host_status[4], 1'b0);
  endtask
  // posted event comes back once on query, then zero
  task t_event;
    axi_wr(`ECHI_OFF_OS_EVT, 32'h33);
    chk(r, 2'h0);
    repeat (2) @(posedge aclk);
    chk(host_status[5], 1'b1);
    chk(host_status[0], 1'b0);
    bin(1'b1, `ECHI_CMD_QUERY);
    echi_host_model_i.get(b);
    chk(b, 8'h33);
    bin(1'b1, `ECHI_CMD_QUERY);
    echi_host_model_i.get(b);
    chk(b, `ECHI_QUERY_NONE);
  endtask
  task t_mgmt;
    axi_wr(`ECHI_OFF_MGMT_EVT, 32'h44);
    repeat (2) @(posedge aclk);
    chk(host_status[6:5], 2'h2);
    n0 = os_n;
    bin(1'b1, `ECHI_CMD_QUERY | 8'h40);
    echi_host_model_i.get(b);
    chk(b, 8'h44);
    chk(os_n - n0, 0);
    chk(mg_n, 2);
  endtask
  // burst left by the total timer, then by a critical event
  task t_abort;
    bin(1'b1, `ECHI_CMD_BURST_ON);
    echi_host_model_i.get(b);
    axi_wr(`ECHI_OFF_MEM, 32'h3C5A);
    chk(r, 2'h2);
    n0 = os_n;
    repeat (200) @(posedge aclk);
    #1;
    chk(host_status[4], 1'b0);
    chk(os_n - n0, 1);
    bin(1'b1, `ECHI_CMD_BURST_ON);
    echi_host_model_i.get(b);
    n0 = os_n;
    axi_wr(`ECHI_OFF_CTRL, 32'h1);
    repeat (2) @(posedge aclk);
    #1;
    chk(host_status[4], 1'b0);
    chk(os_n - n0, 1);
  endtask
  // smbus event queues the header value for the next os query
  task t_smb;
    axi_wr(`ECHI_OFF_CTRL, 32'h5502);
    smb_event <= 1'b1;
    @(posedge aclk);
    smb_event <= 1'b0;
    repeat (3) @(posedge aclk);
    bin(1'b1, `ECHI_CMD_QUERY);
    echi_host_model_i.get(b);
    chk(b, 8'h55);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(host_status, 8'h00);
    axi_rd(8'h40);
    chk(r, 2'h2);
    chk(v, 32'h0);
    t_write();
    t_read();
    t_burst();
    t_abort();
    t_event();
    t_mgmt();
    t_smb();
    complete_run();
  end
  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    complete_run();
  end
endmodule
